// File: sttm_pkg.sv
// Constants, types and bus carriers of the ten-bit standard timer
// Summary of operation
// [R1] Ten-bit up-counter steps on each timer tick
// [R2] P checks top three bits; A checks all
// [R3] On rise clears counter; fall freezes it
// [R4] Overflow or selected match clears counter
// [R5] Hold bit freezes counter; release resumes
// [R6] Clock select picks tick source, 101 stops
// [R7] On rise restores initial pin level
// [R8] Period field gives 128 times value, 0=1024
// [R9] Period zero clears only on overflow
// [R10] Mode field: compare, capture, PWM, counter
// [R11] Software stops timer before changing mode
// [R12] A match drives pin: none/low/high/toggle
// [R13] PWM: inactive, active, PWM, single pulse
// [R14] Capture edge: rise, fall, both, off
// [R15] Requested level equal initial: no change
// [R16] Software changes pin action only when off
// [R17] Initial level bit sets level or polarity
// [R18] Invert bit flips pin except counter mode
// [R19] Swap bit exchanges period and duty sources
// [R20] Clear source: A match, else P/overflow
// [R21] Counter read-only; compare A read/write
// [R22] Clear source 0 raises both flags
// [R23] Duty at or over period gives full duty
// [R24] Match, clear and flag on same tick
package sttm_pkg;

    // ********************************
    // Sizes and register offsets
    // ********************************
    localparam int CNT_W = 10;
    localparam int REG_W = 8;
    localparam logic [7:0] OFS_CTRL0  = 8'h00;
    localparam logic [7:0] OFS_CTRL1  = 8'h04;
    localparam logic [7:0] OFS_CNT_LO = 8'h08;
    localparam logic [7:0] OFS_CNT_HI = 8'h0C;
    localparam logic [7:0] OFS_CMP_LO = 8'h10;
    localparam logic [7:0] OFS_CMP_HI = 8'h14;
    localparam logic [7:0] OFS_FLAGS  = 8'h18;

    // ********************************
    // Field positions and reset values
    // ********************************
    localparam int POS_HOLD  = 7;
    localparam int POS_CLK   = 4;
    localparam int POS_ON    = 3;
    localparam int POS_PER   = 0;
    localparam int POS_MODE  = 6;
    localparam int POS_ACT   = 4;
    localparam int POS_INIT  = 3;
    localparam int POS_INV   = 2;
    localparam int POS_SWAP  = 1;
    localparam int POS_CCLR  = 0;
    localparam int POS_FLG_A = 0;
    localparam int POS_FLG_P = 1;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [9:0] RST_CMP  = 10'h000;
    localparam logic [9:0] RST_CNT  = 10'h000;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    // ********************************
    // Divider counts
    // ********************************
    localparam logic [1:0] SYS_DIV_LAST = 2'h3;
    localparam logic [5:0] HS16_LAST    = 6'h0F;
    localparam logic [5:0] HS64_LAST    = 6'h3F;

    // ********************************
    // Enumerations
    // ********************************
    typedef enum logic [1:0] {
        MODE_CMP = 2'h0,
        MODE_CAP = 2'h1,
        MODE_PWM = 2'h2,
        MODE_CTR = 2'h3
    } sttm_mode_e;

    typedef enum logic [2:0] {
        CK_SYS4 = 3'h0,
        CK_SYS  = 3'h1,
        CK_HS16 = 3'h2,
        CK_HS64 = 3'h3,
        CK_TB   = 3'h4,
        CK_NONE = 3'h5,
        CK_EXTR = 3'h6,
        CK_EXTF = 3'h7
    } sttm_clk_e;

    // ********************************
    // AXI4-Lite carriers
    // ********************************
    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } sttm_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } sttm_axi_rsp_s;

endpackage

// File: sttm_top.sv
// Ten-bit standard timer with AXI4-Lite register slave
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
module sttm_top (
    input  wire logic                   clock,       // System clock
    input  wire logic                   srst,        // Sync reset
    input  wire sttm_pkg::sttm_axi_req_s axiReq,     // Bus request
    output sttm_pkg::sttm_axi_rsp_s     axiRsp,      // Bus answer
    input  wire logic                   highSpeedTick, // High clock
    input  wire logic                   timebaseTick,  // Timebase
    input  wire logic                   extCountInput, // Count pin
    input  wire logic                   pinZeroIn,   // Pin 0 level
    output logic                        pinZeroOut,  // Pin 0 drive
    output logic                        pinZeroOe,   // Pin 0 enable
    input  wire logic                   pinOneIn,    // Pin 1 level
    output logic                        pinOneOut,   // Pin 1 drive
    output logic                        pinOneOe,    // Pin 1 enable
    output logic                        matchAEvent, // A flag pulse
    output logic                        matchPEvent  // P flag pulse
);
    import sttm_pkg::*;
    // ********************************
    // Register storage
    // ********************************
    logic [7:0]       ctrl0_r;
    logic [7:0]       ctrl1_r;
    logic [CNT_W-1:0] cmpA_r;
    logic [CNT_W-1:0] count_r;
    logic             flagA_r;
    logic             flagP_r;
    logic             onPrev_r;
    logic             outLevel_r;
    logic             pulseOn_r;
    // Field views of the control registers
    logic       holdBit;
    sttm_clk_e  clkSel;
    logic       onBit;
    logic [2:0] perField;
    sttm_mode_e mode;
    logic [1:0] pinAct;
    logic       initLevel;
    logic       invertBit;
    logic       swapBit;
    logic       clrSrc;
    assign holdBit   = ctrl0_r[POS_HOLD];
    assign clkSel    = sttm_clk_e'(ctrl0_r[POS_CLK +: 3]);
    assign onBit     = ctrl0_r[POS_ON];
    assign perField  = ctrl0_r[POS_PER +: 3];
    assign mode      = sttm_mode_e'(ctrl1_r[POS_MODE +: 2]); // R10
    assign pinAct    = ctrl1_r[POS_ACT +: 2];
    assign initLevel = ctrl1_r[POS_INIT];
    assign invertBit = ctrl1_r[POS_INV];
    assign swapBit   = ctrl1_r[POS_SWAP];
    assign clrSrc    = ctrl1_r[POS_CCLR];
    // ********************************
    // Pin synchronisers
    // ********************************
    logic [1:0] extSync_r;
    logic [1:0] p0Sync_r;
    logic [1:0] p1Sync_r;
    logic       extLast_r;
    logic       p0Last_r;
    logic       p1Last_r;
    // Two flops per pin, then one more for edge detection
    always_ff @(posedge clock) begin
        if (srst) begin
            extSync_r <= 2'h0;
            p0Sync_r  <= 2'h0;
            p1Sync_r  <= 2'h0;
            extLast_r <= 1'b0;
            p0Last_r  <= 1'b0;
            p1Last_r  <= 1'b0;
        end else begin
            extSync_r <= {extSync_r[0], extCountInput};
            p0Sync_r  <= {p0Sync_r[0], pinZeroIn};
            p1Sync_r  <= {p1Sync_r[0], pinOneIn};
            extLast_r <= extSync_r[1];
            p0Last_r  <= p0Sync_r[1];
            p1Last_r  <= p1Sync_r[1];
        end
    end

    // ********************************
    // Timer tick selection
    // ********************************
    logic [1:0] sysDiv_r;
    logic [5:0] hsDiv_r;
    logic       tick;
    // Free-running prescalers
    always_ff @(posedge clock) begin
        if (srst) begin
            sysDiv_r <= 2'h0;
            hsDiv_r  <= 6'h00;
        end else begin
            sysDiv_r <= sysDiv_r + 2'h1;
            if (highSpeedTick) hsDiv_r <= hsDiv_r + 6'h01;
        end
    end

    // One tick per step of the chosen source
    always_comb begin
        case (clkSel) // R6
            CK_SYS4: tick = (sysDiv_r == SYS_DIV_LAST);
            CK_SYS:  tick = 1'b1;
            CK_HS16: tick = highSpeedTick
                            && (hsDiv_r[3:0] == HS16_LAST[3:0]);
            CK_HS64: tick = highSpeedTick && (hsDiv_r == HS64_LAST);
            CK_TB:   tick = timebaseTick;
            CK_EXTR: tick = extSync_r[1] && !extLast_r;
            CK_EXTF: tick = !extSync_r[1] && extLast_r;
            default: tick = 1'b0;
        endcase
    end

    // ********************************
    // Comparators and clear choice
    // ********************************
    logic [CNT_W:0] cntInc;
    logic [CNT_W:0] perP;
    logic [CNT_W:0] perA;
    logic           matchA;
    logic           matchP;
    logic           clearHit;
    logic           step;
    logic           onRise;
    logic           setA;
    logic           setP;
    assign onRise = onBit && !onPrev_r; // R3
    assign step   = onBit && !holdBit && tick; // R1 R5
    assign cntInc = {1'b0, count_r} + 11'h001;
    // P period is 128 times the field, zero meaning full range
    assign perP   = (perField == 3'h0) ? 11'h400
                                       : {1'b0, perField, 7'h00}; // R8 R9
    assign perA   = (cmpA_r == RST_CMP) ? 11'h400 : {1'b0, cmpA_r};
    // A sees all bits; P sees only the top three
    assign matchA = step && (cntInc == {1'b0, cmpA_r}); // R2 R24
    assign matchP = step && (cntInc == perP); // R2 R24

    // Clear source per mode
    always_comb begin
        case (mode)
            MODE_PWM: clearHit = swapBit ? matchA : matchP; // R19
            MODE_CAP: clearHit = matchP; // R20
            default:  clearHit = clrSrc ? matchA : matchP; // R4 R20
        endcase
    end

    // ********************************
    // Counter
    // ********************************
    // Cleared on enable, cleared on match, else counts up
    always_ff @(posedge clock) begin
        if (srst) begin
            count_r  <= RST_CNT;
            onPrev_r <= 1'b0;
        end else begin
            onPrev_r <= onBit;
            if (onRise) begin
                count_r <= RST_CNT; // R3
            end else if (step && clearHit) begin
                count_r <= RST_CNT; // R4 R9 R24
            end else if (step) begin
                count_r <= cntInc[CNT_W-1:0]; // R1
            end
        end
    end

    // ********************************
    // Capture detection
    // ********************************
    logic pinRise;
    logic pinFall;
    logic capHit;
    assign pinRise = (p0Sync_r[1] && !p0Last_r)
                     || (p1Sync_r[1] && !p1Last_r);
    assign pinFall = (!p0Sync_r[1] && p0Last_r)
                     || (!p1Sync_r[1] && p1Last_r);

    // Trigger edge chosen by the pin action field
    always_comb begin
        case (pinAct) // R14
            2'h0:    capHit = pinRise;
            2'h1:    capHit = pinFall;
            2'h2:    capHit = pinRise || pinFall;
            default: capHit = 1'b0;
        endcase
        capHit = capHit && onBit && (mode == MODE_CAP);
    end

    // Flag sources by mode; clear on A suppresses P in compare and counter modes
    assign setA = (mode == MODE_CAP) ? capHit : matchA; // R22
    assign setP = matchP && !(clrSrc && mode != MODE_CAP
                              && mode != MODE_PWM); // R22
    assign matchAEvent = setA;
    assign matchPEvent = setP;

    // ********************************
    // Output pin level
    // ********************************
    logic [CNT_W:0] perVal;
    logic [CNT_W:0] dutyVal;
    logic           pwmAct;
    logic           preLevel;
    assign perVal  = swapBit ? perA : perP; // R19
    assign dutyVal = swapBit ? perP : {1'b0, cmpA_r}; // R19
    // Duty at or past the period stays active throughout
    assign pwmAct  = (dutyVal >= perVal)
                     || ({1'b0, count_r} < dutyVal); // R23

    // Compare level, single pulse latch
    always_ff @(posedge clock) begin
        if (srst) begin
            outLevel_r <= 1'b0;
            pulseOn_r  <= 1'b0;
        end else if (onRise) begin
            outLevel_r <= initLevel; // R7
            pulseOn_r  <= 1'b1;
        end else if (matchA) begin
            pulseOn_r <= 1'b0;
            if (mode == MODE_CMP) begin
                case (pinAct) // R12 R15
                    2'h1: begin
                        if (initLevel) outLevel_r <= 1'b0;
                    end
                    2'h2: begin
                        if (!initLevel) outLevel_r <= 1'b1;
                    end
                    2'h3: outLevel_r <= !outLevel_r;
                    default: outLevel_r <= outLevel_r;
                endcase
            end
        end
    end

    // Level before inversion, active level set by initial bit
    always_comb begin
        case (pinAct) // R13 R17
            2'h0:    preLevel = !initLevel;
            2'h1:    preLevel = initLevel;
            2'h2:    preLevel = pwmAct ? initLevel : !initLevel;
            default: preLevel = pulseOn_r ? initLevel : !initLevel;
        endcase
        if (mode == MODE_CMP) begin
            preLevel = outLevel_r; // R17
        end
    end

    logic pinDrv_r;
    logic pinOe_r;
    // Registered pin drive, released in capture and counter modes
    always_ff @(posedge clock) begin
        if (srst) begin
            pinDrv_r <= 1'b0;
            pinOe_r  <= 1'b0;
        end else begin
            pinDrv_r <= preLevel ^ invertBit; // R18
            pinOe_r  <= (mode == MODE_CMP) || (mode == MODE_PWM);
        end
    end

    assign pinZeroOut = pinDrv_r;
    assign pinOneOut  = pinDrv_r;
    assign pinZeroOe  = pinOe_r;
    assign pinOneOe   = pinOe_r;
    // ********************************
    // AXI4-Lite slave
    // ********************************
    logic        awHeld_r;
    logic        wHeld_r;
    logic [7:0]  awAddr_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;
    logic        bValid_r;
    logic [1:0]  bResp_r;
    logic        rValid_r;
    logic [1:0]  rResp_r;
    logic [31:0] rData_r;
    logic        doWrite;
    logic        hitA;
    logic        hitW;
    logic        clrA;
    logic        clrP;
    // True for an address that holds a register
    function automatic logic isMapped(input logic [7:0] a);
        case (a)
            OFS_CTRL0, OFS_CTRL1, OFS_CNT_LO, OFS_CNT_HI,
            OFS_CMP_LO, OFS_CMP_HI, OFS_FLAGS: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    assign hitA    = axiReq.awvalid && axiRsp.awready;
    assign hitW    = axiReq.wvalid && axiRsp.wready;
    assign doWrite = awHeld_r && wHeld_r && !bValid_r;
    assign clrA    = doWrite && wStrb_r[0] && (awAddr_r == OFS_FLAGS)
                     && wData_r[POS_FLG_A];
    assign clrP    = doWrite && wStrb_r[0] && (awAddr_r == OFS_FLAGS)
                     && wData_r[POS_FLG_P];

    // Address and data taken in either order
    always_ff @(posedge clock) begin
        if (srst) begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r  <= 32'h0000_0000;
            wStrb_r  <= 4'h0;
            bValid_r <= 1'b0;
            bResp_r  <= RESP_OK;
        end else begin
            if (hitA) begin
                awHeld_r <= 1'b1;
                awAddr_r <= {axiReq.awaddr[7:2], 2'h0};
            end
            if (hitW) begin
                wHeld_r <= 1'b1;
                wData_r <= axiReq.wdata;
                wStrb_r <= axiReq.wstrb;
            end
            if (doWrite) begin
                awHeld_r <= 1'b0;
                wHeld_r  <= 1'b0;
                bValid_r <= 1'b1;
                bResp_r  <= isMapped(awAddr_r) ? RESP_OK : RESP_ERR;
            end else if (bValid_r && axiReq.bready) begin
                bValid_r <= 1'b0;
            end
        end
    end

    // Control and compare registers; capture outranks software
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl0_r <= RST_CTRL;
            ctrl1_r <= RST_CTRL;
            cmpA_r  <= RST_CMP;
        end else begin
            if (doWrite && wStrb_r[0]) begin
                case (awAddr_r) // R21
                    OFS_CTRL0:  ctrl0_r <= wData_r[7:0];
                    OFS_CTRL1:  ctrl1_r <= wData_r[7:0];
                    OFS_CMP_LO: cmpA_r[7:0] <= wData_r[7:0];
                    OFS_CMP_HI: cmpA_r[9:8] <= wData_r[1:0];
                    default:    ctrl0_r <= ctrl0_r;
                endcase
            end
            if (capHit) cmpA_r <= count_r;
        end
    end

    // Sticky flags; a new event wins over a clear
    always_ff @(posedge clock) begin
        if (srst) begin
            flagA_r <= 1'b0;
            flagP_r <= 1'b0;
        end else begin
            flagA_r <= setA || (flagA_r && !clrA); // R22 R24
            flagP_r <= setP || (flagP_r && !clrP); // R22 R24
        end
    end

    // Read path answers one cycle after the address
    always_ff @(posedge clock) begin
        if (srst) begin
            rValid_r <= 1'b0;
            rResp_r  <= RESP_OK;
            rData_r  <= 32'h0000_0000;
        end else if (axiReq.arvalid && axiRsp.arready) begin
            rValid_r <= 1'b1;
            rResp_r  <= isMapped({axiReq.araddr[7:2], 2'h0}) ? RESP_OK
                                                              : RESP_ERR;
            case ({axiReq.araddr[7:2], 2'h0})
                OFS_CTRL0:  rData_r <= {24'h0, ctrl0_r};
                OFS_CTRL1:  rData_r <= {24'h0, ctrl1_r};
                OFS_CNT_LO: rData_r <= {24'h0, count_r[7:0]}; // R21
                OFS_CNT_HI: rData_r <= {30'h0, count_r[9:8]};
                OFS_CMP_LO: rData_r <= {24'h0, cmpA_r[7:0]};
                OFS_CMP_HI: rData_r <= {30'h0, cmpA_r[9:8]};
                OFS_FLAGS:  rData_r <= {30'h0, flagP_r, flagA_r};
                default:    rData_r <= 32'h0000_0000;
            endcase
        end else if (rValid_r && axiReq.rready) begin
            rValid_r <= 1'b0;
        end
    end

    // Handshake outputs
    assign axiRsp.awready = !awHeld_r && !bValid_r;
    assign axiRsp.wready  = !wHeld_r && !bValid_r;
    assign axiRsp.bvalid  = bValid_r;
    assign axiRsp.bresp   = bResp_r;
    assign axiRsp.arready = !rValid_r;
    assign axiRsp.rvalid  = rValid_r;
    assign axiRsp.rresp   = rResp_r;
    assign axiRsp.rdata   = rData_r;

endmodule

// File: sttm_top_assertions.sv
// Port-level assertions for the ten-bit standard timer
`timescale 1ns/10ps
module sttm_top_chk (
    input wire logic                    clock,       // System clock
    input wire logic                    srst,        // Sync reset
    input wire sttm_pkg::sttm_axi_req_s axiReq,      // Bus request
    input wire sttm_pkg::sttm_axi_rsp_s axiRsp,      // Bus answer
    input wire logic                    matchPEvent, // P flag pulse
    input wire logic                    pinZeroOut,  // Pin 0 drive
    input wire logic                    pinZeroOe,   // Pin 0 enable
    input wire logic                    pinOneOut,   // Pin 1 drive
    input wire logic                    pinOneOe     // Pin 1 enable
);
    import sttm_pkg::*;

    logic [7:0] ctrlShadow_r;
    logic       wrTaken;
    logic       rdTaken;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    // Handshakes seen on this edge
    assign wrTaken = axiReq.awvalid && axiRsp.awready
                     && axiReq.wvalid && axiRsp.wready;
    assign rdTaken = axiReq.arvalid && axiRsp.arready;

    // Follows what software writes to the mode and output byte
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrlShadow_r <= 8'h00;
        end else if (wrTaken && axiReq.awaddr == OFS_CTRL1) begin
            ctrlShadow_r <= axiReq.wdata[7:0];
        end
    end

    property p_w_answer;
        wrTaken && axiReq.awaddr <= OFS_FLAGS
        |-> ##2 axiRsp.bvalid && axiRsp.bresp == RESP_OK;
    endproperty
    a_w_answer: assert property (p_w_answer)
        else $error("write answer missing");

    property p_b_once;
        axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid;
    endproperty
    a_b_once: assert property (p_b_once)
        else $error("write answer repeated");

    property p_r_answer;
        rdTaken && axiReq.araddr <= OFS_FLAGS
        |=> axiRsp.rvalid && axiRsp.rresp == RESP_OK;
    endproperty
    a_r_answer: assert property (p_r_answer)
        else $error("read answer missing");

    property p_r_refuse;
        axiRsp.rvalid |-> !axiRsp.arready;
    endproperty
    a_r_refuse: assert property (p_r_refuse)
        else $error("read taken while answer pending");

    property p_unmapped;
        rdTaken && axiReq.araddr[7:2] > OFS_FLAGS[7:2] |=> axiRsp.rvalid
        && axiRsp.rresp == RESP_ERR && axiRsp.rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");

    property p_pins_same;
        pinZeroOut == pinOneOut && pinZeroOe == pinOneOe;
    endproperty
    a_pins_same: assert property (p_pins_same)
        else $error("timer pins differ");

    property p_only_a;
        ctrlShadow_r[0] && ctrlShadow_r[7] == ctrlShadow_r[6]
        |-> !matchPEvent;
    endproperty
    a_only_a: assert property (p_only_a)
        else $error("P flag with clear on A");

    property p_ctr_oe;
        ctrlShadow_r[7:6] == 2'b11 |-> ##2 !pinZeroOe;
    endproperty
    a_ctr_oe: assert property (p_ctr_oe)
        else $error("pin driven in counter mode");
endmodule

// File: sttm_top_bench.sv
// Self-checking bench for the ten-bit standard timer
`timescale 1ns/10ps
module sttm_top_bench;
    import sttm_pkg::*;

    // Stimulus, observed outputs and scenario counters
    logic          clock;
    logic          srst;
    sttm_axi_req_s axiReq;
    sttm_axi_rsp_s axiRsp;
    logic          hsTick;
    logic          pinIn;
    logic          pinOut;
    logic          matchA;
    logic          matchP;
    logic [31:0]   rdat;
    logic [31:0]   v;
    logic [1:0]    resp;
    int            na;
    int            np;
    int            nh;
    int            nt;
    int            n_fail;
    int            checked;
    int            cyc;

    sttm_top i_sttm_top (
        .clock(clock), .srst(srst), .axiReq(axiReq), .axiRsp(axiRsp),
        .highSpeedTick(hsTick), .timebaseTick(1'b0),
        .extCountInput(1'b0), .pinZeroIn(pinIn), .pinZeroOut(pinOut),
        .pinZeroOe(), .pinOneIn(1'b0), .pinOneOut(), .pinOneOe(),
        .matchAEvent(matchA), .matchPEvent(matchP)
    );

    // Clock, high clock enable every other cycle, hang guard
    always #2 clock = ~clock;
    always @(posedge clock) begin
        hsTick <= ~hsTick;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end

    task automatic results;
        if (n_fail == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Bus write; each channel dropped at the rising edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ga = 1'b0;
        logic gw = 1'b0;
        axiReq.awaddr <= a;
        axiReq.wdata <= d;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid <= 1'b1;
        while (!(ga && gw)) begin
            @(posedge clock);
            if (axiRsp.awready) ga = 1'b1;
            if (axiRsp.wready) gw = 1'b1;
            if (ga) axiReq.awvalid <= 1'b0;
            if (gw) axiReq.wvalid <= 1'b0;
        end
        do @(posedge clock); while (!axiRsp.bvalid);
    endtask

    task automatic rd(input logic [7:0] a);
        axiReq.araddr <= a;
        axiReq.arvalid <= 1'b1;
        do @(posedge clock); while (!axiRsp.arready);
        axiReq.arvalid <= 1'b0;
        do @(posedge clock); while (!axiRsp.rvalid);
        rdat = axiRsp.rdata;
        resp = axiRsp.rresp;
    endtask

    // Timer off, new mode byte, then switch on with c0
    task automatic setup(input logic [7:0] c1, input logic [7:0] c0);
        wr(OFS_CTRL0, 32'h0);
        wr(OFS_CTRL1, {24'h0, c1});
        wr(OFS_CTRL0, {24'h0, c0});
        repeat (4) @(posedge clock);
    endtask

    // Counts flag pulses and pin activity over n cycles
    task automatic watch(input int n);
        logic last;
        na = 0;
        np = 0;
        nh = 0;
        nt = 0;
        last = pinOut;
        repeat (n) begin
            @(negedge clock);
            na += matchA;
            np += matchP;
            nh += pinOut;
            nt += int'(pinOut != last);
            last = pinOut;
        end
        @(posedge clock);
    endtask

    task automatic t_regs;
        for (int a = 0; a < 24; a += 4) begin
            rd(8'(a));
            chk(rdat, 32'h0);
        end
        wr(OFS_CNT_LO, 32'hFF);
        rd(OFS_CNT_LO);
        chk(rdat, 32'h0);
        wr(OFS_CMP_LO, 32'h1AB);
        wr(OFS_CMP_HI, 32'hFF);
        rd(OFS_CMP_LO);
        chk(rdat, 32'hAB);
        rd(OFS_CMP_HI);
        chk(rdat, 32'h3);
        rd(8'h1C);
        chk({rdat[29:0], resp}, {30'h0, RESP_ERR});
    endtask

    task automatic t_cmp;
        wr(OFS_CMP_LO, 32'h5);
        wr(OFS_CMP_HI, 32'h0);
        setup(8'h31, 8'h18);
        watch(50);
        chk(na, 10);
        chk(np, 0);
        chk(nt, 10);
        setup(8'h29, 8'h18);
        watch(30);
        chk(nh, 30);
        setup(8'h2D, 8'h18);
        watch(30);
        chk(nh, 0);
        setup(8'hC0, 8'h18);
    endtask

    task automatic t_clk;
        int lo[8] = '{32, 130, 4, 1, 0, 0, 0, 0};
        wr(OFS_CMP_LO, 32'h0);
        for (int k = 0; k < 8; k++) begin
            setup(8'h01, {1'b0, 3'(k), 4'h8});
            rd(OFS_CNT_LO);
            v = rdat;
            repeat (128) @(posedge clock);
            rd(OFS_CNT_LO);
            v = rdat - v;
            chk(32'(v >= lo[k] && v <= lo[k] + 1), 32'h1);
        end
    endtask

    task automatic t_hold;
        wr(OFS_CTRL0, 32'h18);
        repeat (20) @(posedge clock);
        wr(OFS_CTRL0, 32'h10);
        rd(OFS_CNT_LO);
        v = rdat;
        repeat (9) @(posedge clock);
        rd(OFS_CNT_LO);
        chk(rdat, v);
        wr(OFS_CTRL0, 32'h98);
        repeat (9) @(posedge clock);
        rd(OFS_CNT_LO);
        chk(rdat, 32'h0);
        wr(OFS_CTRL0, 32'h18);
        rd(OFS_CNT_LO);
        chk(32'(rdat != 0), 32'h1);
    endtask

    task automatic t_per;
        wr(OFS_CMP_LO, 32'h3);
        setup(8'h00, 8'h19);
        watch(512);
        chk(np, 4);
        chk(na, 4);
        setup(8'h00, 8'h18);
        watch(2048);
        chk(np, 2);
        chk(na, 2);
    endtask

    // Mode byte, compare A, window, high cycles; pulse has slack
    task automatic t_pwm;
        logic [7:0] c1[8] = '{8'hA8, 8'hA8, 8'hAC, 8'hAA,
                              8'h88, 8'h98, 8'hA0, 8'hB8};
        int cmp[8] = '{32, 200, 32, 512, 32, 32, 32, 40};
        int win[8] = '{256, 256, 256, 512, 256, 256, 256, 256};
        int hi[8] = '{64, 256, 192, 128, 0, 256, 192, 40};
        for (int k = 0; k < 8; k++) begin
            wr(OFS_CMP_LO, cmp[k]);
            wr(OFS_CMP_HI, cmp[k] >> 8);
            setup(c1[k], 8'h19);
            watch(win[k]);
            v = 32'(nh <= hi[k] && nh + (k == 7 ? 10 : 0) >= hi[k]);
            chk(v, 32'h1);
        end
    endtask

    task automatic t_cap;
        int nCap[4] = '{1, 1, 2, 0};
        for (int k = 0; k < 4; k++) begin
            setup({2'b01, 2'(k), 4'h0}, 8'h58);
            fork
                watch(40);
                begin
                    repeat (10) @(posedge clock);
                    pinIn <= 1'b1;
                    repeat (10) @(posedge clock);
                    pinIn <= 1'b0;
                end
            join
            chk(na, nCap[k]);
        end
    endtask

    // Reset for two cycles, then the scenarios in turn
    initial begin
        clock = 1'b0;
        srst = 1'b1;
        axiReq = '0;
        axiReq.wstrb = 4'hF;
        axiReq.bready = 1'b1;
        axiReq.rready = 1'b1;
        hsTick = 1'b0;
        pinIn = 1'b0;
        n_fail = 0;
        checked = 0;
        cyc = 0;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        t_regs();
        t_cmp();
        t_clk();
        t_hold();
        t_per();
        t_pwm();
        t_cap();
        results();
    end
endmodule

bind sttm_top sttm_top_chk i_sttm_top_chk (
    .clock(clock), .srst(srst), .axiReq(axiReq), .axiRsp(axiRsp),
    .matchPEvent(matchPEvent), .pinZeroOut(pinZeroOut),
    .pinZeroOe(pinZeroOe), .pinOneOut(pinOneOut), .pinOneOe(pinOneOe)
);
